// File: inc/lcd_rst_consts.svh
`ifndef LCD_RST_CONSTS_SVH
`define LCD_RST_CONSTS_SVH

// ==========================================
// Instruction word layout
`define INSTR_W 16
`define OP_MSB 15
`define OP_LSB 12
`define ARG_W 12

// ==========================================
// Opcodes
`define OP_DISP_CTRL 4'h1
`define OP_KEY_STATE 4'h2
`define OP_GP_STATE 4'h3
`define OP_TECHNIQUE 4'h4
`define OP_SET_ADDR 4'h5
`define OP_CONTRAST 4'h6
`define OP_KEY_READ 4'h7

// ==========================================
// Argument fields
`define DISP_ON_BIT 0
`define DISP_SLEEP_BIT 1
`define TECH_COM_BIT 0
`define TECH_DUTY_LSB 1
`define CONTRAST_EN_BIT 4

// ==========================================
// Widths and reset values
`define KEY_OUT_W 6
`define KEY_DATA_W 30
`define GP_W 4
`define ADDR_W 6
`define DUTY_W 2
`define CONTRAST_W 4
`define RST_KEY_OUT 6'h00
`define RST_KEY_DATA 30'h0000_0000
`define RST_GP 4'h0
`define RST_ADDR 6'h00
`define RST_DUTY 2'h0
`define RST_CONTRAST 4'h0
`define RST_BITCNT 5'h00

`endif

// File: inc/lcd_rst_pkg.sv
package lcd_rst_pkg;
	typedef enum logic [1:0] {
		SYS_RESET = 2'b00,
		SYS_WAIT_INIT = 2'b01,
		SYS_RUN = 2'b10
	} sys_state_t;

	typedef enum logic {
		RX_WAIT = 1'b0,
		RX_SHIFT = 1'b1
	} rx_state_t;
endpackage

// File: verilog/sync2.sv
`timescale 1ns/10ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d_async,
	output logic [WIDTH-1:0] q_sync
);
	logic [WIDTH-1:0] meta_ff;

	// ==========================================
	// Two stages, first stage read only by second
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_ff <= '0;
			q_sync <= '0;
		end else begin
			meta_ff <= d_async;
			q_sync <= meta_ff;
		end
	end
endmodule // sync2

// File: verilog/serial_rx.sv
`timescale 1ns/10ps
`include "lcd_rst_consts.svh"
module serial_rx #(
	parameter int WORD_W = `INSTR_W
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clr,
	input wire logic ce_s,
	input wire logic cl_s,
	input wire logic di_s,
	output logic [WORD_W-1:0] word_data,
	output logic word_strobe
);
	import lcd_rst_pkg::*;

	rx_state_t state_ff;
	logic cl_d_ff;
	logic [WORD_W-1:0] shift_ff;
	logic [4:0] cnt_ff;
	wire cl_rise = cl_s && !cl_d_ff;

	always_ff @(posedge clk_sys) begin
		if (!rstn || clr) begin
			cl_d_ff <= 1'b0;
		end else begin
			cl_d_ff <= cl_s;
		end
	end

	// ==========================================
	// Shift register, back to waiting on reset
	always_ff @(posedge clk_sys) begin
		if (!rstn || clr) begin
			state_ff <= RX_WAIT;
			shift_ff <= '0;
			cnt_ff <= `RST_BITCNT;
			word_strobe <= 1'b0;
			word_data <= '0;
		end else begin
			word_strobe <= 1'b0;
			case (state_ff)
				RX_WAIT: begin
					cnt_ff <= `RST_BITCNT;
					if (ce_s) begin
						state_ff <= RX_SHIFT;
					end
				end
				RX_SHIFT: begin
					if (cl_rise && cnt_ff < 5'(WORD_W)) begin
						shift_ff <= {di_s, shift_ff[WORD_W-1:1]};
						cnt_ff <= cnt_ff + 5'h01;
					end
					// Short frames are dropped, never half executed
					if (!ce_s) begin
						state_ff <= RX_WAIT;
						if (cnt_ff == 5'(WORD_W)) begin
							word_data <= shift_ff;
							word_strobe <= 1'b1;
						end
					end
				end
				default: state_ff <= RX_WAIT;
			endcase
		end
	end
endmodule // serial_rx

// File: verilog/lcd_ctrl_system_reset.sv
`timescale 1ns/10ps
`include "lcd_rst_consts.svh"
module lcd_ctrl_system_reset (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic supply_detect_reset,
	input wire logic inhibit_input_n,
	input wire logic ser_ce,
	input wire logic ser_cl,
	input wire logic ser_di,
	input wire logic [`KEY_DATA_W-1:0] key_matrix,
	output lcd_rst_pkg::sys_state_t sys_state,
	output logic osc_run,
	output logic display_on,
	output logic sleep_mode,
	output logic drv_blank,
	output logic latch_load,
	output logic seg_com_common,
	output logic [`DUTY_W-1:0] duty_sel,
	output logic [`ADDR_W-1:0] address_counter,
	output logic contrast_en,
	output logic [`CONTRAST_W-1:0] contrast_level,
	output logic key_scan_active,
	output logic [`KEY_OUT_W-1:0] key_scan_outputs,
	output logic [`KEY_DATA_W-1:0] key_data,
	output logic key_req_out,
	output logic key_req_oe,
	output logic [`GP_W-1:0] general_outputs
);
	import lcd_rst_pkg::*;

	// ==========================================
	// Pin synchronisers
	logic det_s;
	logic inh_n_s;
	logic ce_s;
	logic cl_s;
	logic di_s;
	logic [`KEY_DATA_W-1:0] key_s;

	sync2 #(.WIDTH(5)) u_pin_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d_async({supply_detect_reset, inhibit_input_n, ser_ce, ser_cl, ser_di}),
		.q_sync({det_s, inh_n_s, ce_s, cl_s, di_s})
	);

	// Key lines sampled together; a torn sample stays in key_data until a press is captured after the next key read
	sync2 #(.WIDTH(`KEY_DATA_W)) u_key_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d_async(key_matrix),
		.q_sync(key_s)
	);

	// Level reset: held as long as the detector says so
	logic sys_rst;
	assign sys_rst = !rstn || det_s;

	logic inh_act;
	assign inh_act = !inh_n_s;

	// ==========================================
	// Serial interface
	logic [`INSTR_W-1:0] rx_word;
	logic rx_valid;

	serial_rx #(.WORD_W(`INSTR_W)) u_rx (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clr(det_s),
		.ce_s(ce_s),
		.cl_s(cl_s),
		.di_s(di_s),
		.word_data(rx_word),
		.word_strobe(rx_valid)
	);

	// ==========================================
	// Instruction register and decoder
	logic [`INSTR_W-1:0] instr_ff;
	logic instr_vld_ff;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			instr_ff <= '0;
			instr_vld_ff <= 1'b0;
		end else begin
			instr_ff <= rx_word;
			instr_vld_ff <= rx_valid;
		end
	end

	function automatic logic is_op(input logic [`INSTR_W-1:0] w, input logic [3:0] op);
		is_op = (w[`OP_MSB:`OP_LSB] == op);
	endfunction

	logic [`ARG_W-1:0] arg;
	logic cmd_disp;
	logic cmd_key;
	logic cmd_gp;
	logic cmd_tech;
	logic cmd_addr;
	logic cmd_contrast;
	logic cmd_key_read;

	assign arg = instr_ff[`ARG_W-1:0];
	assign cmd_disp = instr_vld_ff && is_op(instr_ff, `OP_DISP_CTRL);
	assign cmd_key = instr_vld_ff && is_op(instr_ff, `OP_KEY_STATE);
	assign cmd_gp = instr_vld_ff && is_op(instr_ff, `OP_GP_STATE);
	assign cmd_tech = instr_vld_ff && is_op(instr_ff, `OP_TECHNIQUE);
	assign cmd_addr = instr_vld_ff && is_op(instr_ff, `OP_SET_ADDR);
	assign cmd_contrast = instr_vld_ff && is_op(instr_ff, `OP_CONTRAST);
	assign cmd_key_read = instr_vld_ff && is_op(instr_ff, `OP_KEY_READ);

	// ==========================================
	// Sequencer state
	sys_state_t nxt_state;

	always_comb begin
		nxt_state = sys_state;
		case (sys_state)
			SYS_RESET: nxt_state = SYS_WAIT_INIT;
			SYS_WAIT_INIT: begin
				if (cmd_disp && arg[`DISP_ON_BIT]) begin
					nxt_state = SYS_RUN;
				end
			end
			SYS_RUN: nxt_state = SYS_RUN;
			default: nxt_state = SYS_RESET;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sys_state <= SYS_RESET;
		end else begin
			sys_state <= nxt_state;
		end
	end

	// ==========================================
	// Clock generator
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			osc_run <= 1'b1;
			sleep_mode <= 1'b0;
		end else if (cmd_disp) begin
			sleep_mode <= arg[`DISP_SLEEP_BIT];
			// Sleep stops the base clock; key wake is outside this block
			osc_run <= !arg[`DISP_SLEEP_BIT];
		end
	end

	// ==========================================
	// Display control, latch and drivers
	logic disp_en_ff;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			disp_en_ff <= 1'b0;
		end else if (cmd_disp) begin
			disp_en_ff <= arg[`DISP_ON_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			display_on <= 1'b0;
			drv_blank <= 1'b1;
		end else begin
			display_on <= disp_en_ff && !inh_act;
			drv_blank <= !(disp_en_ff && !inh_act);
		end
	end

	// Latch content is undefined until this pulse; no reset load
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			latch_load <= 1'b0;
		end else begin
			latch_load <= cmd_disp;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			seg_com_common <= 1'b0;
			duty_sel <= `RST_DUTY;
		end else if (cmd_tech) begin
			seg_com_common <= arg[`TECH_COM_BIT];
			duty_sel <= arg[`TECH_DUTY_LSB +: `DUTY_W];
		end
	end

	// ==========================================
	// Address counter; RAM arrays live elsewhere, left uncleared on purpose
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			address_counter <= `RST_ADDR;
		end else if (cmd_addr) begin
			address_counter <= arg[`ADDR_W-1:0];
		end
	end

	// ==========================================
	// Contrast adjuster
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			contrast_en <= 1'b0;
			contrast_level <= `RST_CONTRAST;
		end else if (cmd_contrast) begin
			contrast_en <= arg[`CONTRAST_EN_BIT];
			contrast_level <= arg[`CONTRAST_W-1:0];
		end
	end

	// ==========================================
	// Key scan and key buffer
	logic key_en_ff;
	logic [`KEY_OUT_W-1:0] key_lvl_ff;
	logic key_pend_ff;
	logic nxt_pend;
	logic key_hit;

	assign key_hit = key_en_ff && !inh_act && (|key_s) && !key_pend_ff;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			key_en_ff <= 1'b0;
			key_lvl_ff <= `RST_KEY_OUT;
		end else if (cmd_key) begin
			key_en_ff <= 1'b1;
			key_lvl_ff <= arg[`KEY_OUT_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			key_data <= `RST_KEY_DATA;
		end else if (key_hit) begin
			key_data <= key_s;
		end
	end

	// New press wins over a read in the same cycle
	always_comb begin
		nxt_pend = key_pend_ff;
		if (cmd_key_read) begin
			nxt_pend = 1'b0;
		end
		if (key_hit) begin
			nxt_pend = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			key_pend_ff <= 1'b0;
		end else begin
			key_pend_ff <= nxt_pend;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			key_scan_active <= 1'b0;
			key_scan_outputs <= `RST_KEY_OUT;
			key_req_out <= 1'b0;
			key_req_oe <= 1'b0;
		end else begin
			key_scan_active <= key_en_ff && !inh_act;
			key_scan_outputs <= (key_en_ff && !inh_act) ? key_lvl_ff : `RST_KEY_OUT;
			key_req_out <= 1'b0;
			// Released during a transfer and before the scan is set up
			key_req_oe <= key_en_ff && nxt_pend && !ce_s;
		end
	end

	// ==========================================
	// General outputs
	logic gp_unlock_ff;
	logic [`GP_W-1:0] gp_lvl_ff;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gp_unlock_ff <= 1'b0;
			gp_lvl_ff <= `RST_GP;
		end else if (cmd_gp) begin
			gp_unlock_ff <= 1'b1;
			gp_lvl_ff <= arg[`GP_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			general_outputs <= `RST_GP;
		end else begin
			general_outputs <= (gp_unlock_ff && !inh_act) ? gp_lvl_ff : `RST_GP;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_RESET_BLANK: assert property (sys_rst |=> drv_blank && !display_on && !key_scan_active)
		else $error("reset did not blank display and key scan");
	AST_RESET_HOLD_TWO: assert property (sys_rst ##1 sys_rst |=> general_outputs == `RST_GP
		&& key_data == `RST_KEY_DATA && key_scan_outputs == `RST_KEY_OUT)
		else $error("forced outputs not held during reset");
	AST_DISP_BY_CMD: assert property ($rose(disp_en_ff) |-> $past(cmd_disp && arg[`DISP_ON_BIT]))
		else $error("display enabled without instruction");
	AST_KEY_BY_CMD: assert property ($rose(key_en_ff) |-> $past(cmd_key))
		else $error("key scan enabled without instruction");
	AST_GP_LEVEL: assert property (cmd_gp && !sys_rst ##1 !sys_rst && !inh_act
		|=> general_outputs == $past(arg[`GP_W-1:0], 2))
		else $error("general outputs not at commanded level");
	AST_GP_LOCK: assert property (!gp_unlock_ff |=> general_outputs == `RST_GP)
		else $error("general outputs left low lock early");
	AST_OSC_FORCED: assert property (sys_rst |=> osc_run)
		else $error("oscillator not forced on in reset");
	AST_DECODER_INIT: assert property (sys_rst |=> !instr_vld_ff)
		else $error("instruction register not cleared");
	AST_ADDR_ONLY_CMD: assert property (!sys_rst && !cmd_addr |=> $stable(address_counter))
		else $error("address counter moved without instruction");
	AST_LATCH_PULSE: assert property (cmd_disp && !sys_rst |=> latch_load ##1 !latch_load || $past(cmd_disp))
		else $error("latch not loaded on display control");
	AST_CONTRAST_OFF: assert property ($rose(contrast_en) |-> $past(cmd_contrast))
		else $error("contrast enabled without instruction");
	AST_SEG_DEFAULT: assert property (sys_rst |=> !seg_com_common)
		else $error("shared pin not segment in reset");
	AST_REQ_RELEASED: assert property (!key_en_ff |=> !key_req_oe)
		else $error("key request driven before key state set");
	AST_RX_WAIT: assert property (det_s |=> !rx_valid)
		else $error("serial word delivered during reset");

	COV_DISPLAY_ON: cover property (sys_state == SYS_WAIT_INIT ##1 sys_state == SYS_RUN);
	COV_KEY_REQ: cover property (key_en_ff ##[1:20] key_req_oe);
	COV_GP_SET: cover property (cmd_gp ##2 general_outputs != `RST_GP);
	COV_REDETECT: cover property (sys_state == SYS_RUN ##1 det_s);
endmodule // lcd_ctrl_system_reset

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
	input wire logic clk_sys,
	output logic ser_ce,
	output logic ser_cl,
	output logic ser_di
);
	// ==========
	// Serial host
	bit slow;
	initial begin
		ser_ce = 1'b0;
		ser_cl = 1'b0;
		ser_di = 1'b0;
		slow = 1'b0;
	end
	// Clock idles low between frames; released data shows inverse
	task automatic send(input logic [15:0] w, input int n);
		int h;
		h = slow ? 6 : 3;
		@(posedge clk_sys);
		ser_ce <= 1'b1;
		for (int i = 0; i < n; i++) begin
			ser_di <= w[i];
			repeat (h) @(posedge clk_sys);
			ser_cl <= 1'b1;
			repeat (h) @(posedge clk_sys);
			ser_cl <= 1'b0;
		end
		repeat (h) @(posedge clk_sys);
		ser_ce <= 1'b0;
		ser_di <= ~ser_di;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule // host_model

// File: tb/lcd_ctrl_system_reset_tb.sv
`timescale 1ns/10ps
`include "lcd_rst_consts.svh"
module lcd_ctrl_system_reset_tb;
	import lcd_rst_pkg::*;
	typedef struct packed {
		logic [1:0] st;
		logic dsp, blank, osc, sl, com;
		logic [1:0] duty;
		logic [5:0] addr;
		logic cen;
		logic [3:0] clev;
		logic kact;
		logic [5:0] ks;
		logic [3:0] gp;
	} snap_t;
	localparam snap_t RST_SNAP = '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 1'b0, 4'h0, 1'b0, 6'h00, 4'h0};
	logic clk_sys, rstn, supply_detect_reset, inhibit_input_n, ser_ce, ser_cl, ser_di;
	logic [`KEY_DATA_W-1:0] key_matrix, key_data;
	sys_state_t sys_state;
	logic osc_run, display_on, sleep_mode, drv_blank, latch_load, seg_com_common, contrast_en;
	logic key_scan_active, key_req_oe, key_req_out;
	logic [`DUTY_W-1:0] duty_sel;
	logic [`ADDR_W-1:0] address_counter;
	logic [`CONTRAST_W-1:0] contrast_level;
	logic [`KEY_OUT_W-1:0] key_scan_outputs;
	logic [`GP_W-1:0] general_outputs;
	snap_t q[$];
	snap_t cur, last;
	bit mon_on;
	int fail_count = 0;
	int n_tests = 0;
	int n_latch = 0;

	lcd_ctrl_system_reset i_lcd_ctrl_system_reset (.clk_sys(clk_sys), .rstn(rstn),
		.supply_detect_reset(supply_detect_reset), .inhibit_input_n(inhibit_input_n), .ser_ce(ser_ce),
		.ser_cl(ser_cl), .ser_di(ser_di), .key_matrix(key_matrix), .sys_state(sys_state),
		.osc_run(osc_run), .display_on(display_on), .sleep_mode(sleep_mode), .drv_blank(drv_blank),
		.latch_load(latch_load), .seg_com_common(seg_com_common), .duty_sel(duty_sel),
		.address_counter(address_counter), .contrast_en(contrast_en), .contrast_level(contrast_level),
		.key_scan_active(key_scan_active), .key_scan_outputs(key_scan_outputs), .key_data(key_data),
		.key_req_out(key_req_out), .key_req_oe(key_req_oe), .general_outputs(general_outputs));
	host_model i_host_model (.clk_sys(clk_sys), .ser_ce(ser_ce), .ser_cl(ser_cl), .ser_di(ser_di));

	// ==========
	// Helpers
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (latch_load === 1'b1) n_latch <= n_latch + 1;
	end
	function automatic snap_t snap();
		return {sys_state, display_on, drv_blank, osc_run, sleep_mode, seg_com_common, duty_sel, address_counter,
			contrast_en, contrast_level, key_scan_active, key_scan_outputs, general_outputs};
	endfunction
	function automatic snap_t apply(snap_t c, logic [3:0] op, logic [11:0] a);
		snap_t e;
		e = c;
		case (op)
			`OP_DISP_CTRL: begin
				e.dsp = a[0];
				e.blank = ~a[0];
				e.sl = a[1];
				e.osc = ~a[1];
				if (a[0]) e.st = 2'h2;
			end
			`OP_KEY_STATE: begin
				e.kact = 1'b1;
				e.ks = a[5:0];
			end
			`OP_GP_STATE: e.gp = a[3:0];
			`OP_TECHNIQUE: begin
				e.com = a[0];
				e.duty = a[2:1];
			end
			`OP_SET_ADDR: e.addr = a[5:0];
			`OP_CONTRAST: begin
				e.clev = a[3:0];
				e.cen = a[4];
			end
			default: ;
		endcase
		return e;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic err(input string m);
		fail_count++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_snap(input snap_t e, input snap_t g);
		n_tests++;
		if (g !== e) err($sformatf("state got %h exp %h", g, e));
	endtask
	task automatic chk_key(input logic [`KEY_DATA_W-1:0] e, input logic [`KEY_DATA_W-1:0] g);
		n_tests++;
		if (g !== e) err($sformatf("key data got %h exp %h", g, e));
	endtask
	task automatic chk_flag(input logic e, input logic g);
		n_tests++;
		if (g !== e) err($sformatf("flag got %b exp %b", g, e));
	endtask
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (q.size() != 0 && k < 200) begin
			@(posedge clk_sys);
			k++;
		end
		if (q.size() != 0) begin
			err("no response");
			wrap_up();
		end else begin
			tick(2);
		end
	endtask
	// Same-value arguments would leave nothing to observe, so bit 0 is flipped
	task automatic instr(input logic [3:0] op, input logic [11:0] a);
		snap_t e;
		int nl;
		e = apply(cur, op, a);
		if (e === cur && op != `OP_KEY_READ) begin
			a[0] = ~a[0];
			e = apply(cur, op, a);
		end
		nl = n_latch;
		if (e !== cur) q.push_back(e);
		cur = e;
		i_host_model.send({op, a}, 16);
		wait_idle();
		if (op == `OP_DISP_CTRL) chk_flag(1'b1, n_latch == nl + 1);
	endtask

	// ==========
	// Output watcher
	initial begin
		forever begin
			@(posedge clk_sys);
			#1;
			if (mon_on && snap() !== last) begin
				tick(3);
				if (q.size() == 0) err("unexpected change");
				else chk_snap(q.pop_front(), snap());
				last = snap();
			end
		end
	end

	// ==========
	// Main sequence
	initial begin
		logic [`KEY_DATA_W-1:0] kv;
		snap_t e;
		rstn = 1'b0;
		supply_detect_reset = 1'b0;
		inhibit_input_n = 1'b1;
		key_matrix = '0;
		void'($urandom(32'hff4e));
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		key_matrix <= `KEY_DATA_W'($urandom()) | 30'h0000_0001;
		tick(8);
		cur = RST_SNAP;
		chk_snap(RST_SNAP, snap());
		chk_key('0, key_data);
		chk_flag(1'b0, key_req_oe);
		last = snap();
		mon_on = 1'b1;
		i_host_model.slow = 1'b1;
		instr(`OP_KEY_READ, 12'h000);
		chk_flag(1'b0, key_req_oe);
		chk_key('0, key_data);
		@(posedge clk_sys);
		key_matrix <= '0;
		// Short frame and undecoded opcode must leave every output alone
		i_host_model.send({`OP_GP_STATE, 12'h00f}, 15);
		i_host_model.send({4'h0, 12'($urandom())}, 16);
		tick(10);
		i_host_model.slow = 1'b0;
		for (int r = 0; r < 2; r++) begin
			instr(`OP_TECHNIQUE, 12'($urandom()));
			instr(`OP_SET_ADDR, 12'($urandom()));
			instr(`OP_CONTRAST, 12'($urandom()) | 12'h010);
			instr(`OP_GP_STATE, 12'($urandom()));
			instr(`OP_KEY_STATE, 12'($urandom()));
		end
		instr(`OP_DISP_CTRL, 12'h001);
		instr(`OP_DISP_CTRL, 12'h003);
		instr(`OP_DISP_CTRL, 12'h001);
		kv = `KEY_DATA_W'($urandom()) | 30'h0000_0001;
		@(posedge clk_sys);
		key_matrix <= kv;
		tick(8);
		chk_key(kv, key_data);
		chk_flag(1'b1, key_req_oe);
		chk_flag(1'b0, key_req_out);
		@(posedge clk_sys);
		key_matrix <= '0;
		instr(`OP_KEY_READ, 12'h000);
		chk_flag(1'b0, key_req_oe);
		mon_on = 1'b0;
		@(posedge clk_sys);
		inhibit_input_n <= 1'b0;
		tick(6);
		chk_flag(1'b1, drv_blank);
		chk_flag(1'b1, {key_scan_outputs, general_outputs} === '0);
		@(posedge clk_sys);
		inhibit_input_n <= 1'b1;
		tick(6);
		chk_snap(cur, snap());
		last = snap();
		mon_on = 1'b1;
		instr(`OP_DISP_CTRL, 12'h000);
		mon_on = 1'b0;
		@(posedge clk_sys);
		supply_detect_reset <= 1'b1;
		tick(6);
		e = RST_SNAP;
		e.st = 2'h0;
		chk_snap(e, snap());
		chk_key('0, key_data);
		chk_flag(1'b0, key_req_oe);
		tick(10);
		chk_snap(e, snap());
		@(posedge clk_sys);
		supply_detect_reset <= 1'b0;
		tick(6);
		cur = RST_SNAP;
		chk_snap(RST_SNAP, snap());
		last = snap();
		mon_on = 1'b1;
		instr(`OP_GP_STATE, 12'h005);
		wrap_up();
	end
endmodule // lcd_ctrl_system_reset_tb
